// *** rtl/swdiag_pkg.sv ***
// package: register map, field layout and carrier types for the switch diagnostics block
package swdiag_pkg;
    localparam int N_CH = 4;
    // register byte addresses on the apb bus
    localparam logic [7:0] ADDR_SUMMARY = 8'h00;
    localparam logic [7:0] ADDR_DIAG21 = 8'h04;
    localparam logic [7:0] ADDR_DIAG43 = 8'h08;
    localparam logic [7:0] ADDR_ENABLE = 8'h0C;
    localparam logic [7:0] ADDR_STATE = 8'h10;
    localparam logic [7:0] ADDR_FAULT_MAP = 8'h14;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h18;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h1C;
    localparam logic [7:0] ADDR_CLEAR = 8'h20;
    // summary register fields
    localparam int SUM_LINK_ERR = 7;
    localparam int SUM_OVERTEMP = 6;
    localparam int SUM_SUPPLY_OS = 5;
    localparam int SUM_SUPPLY_LOW = 4;
    // channel pair register fields
    localparam int CHANNEL_DIAGNOSTIC_REGISTER_OC_HI = 7;
    localparam int CHANNEL_DIAGNOSTIC_REGISTER_OT_HI = 5;
    localparam int CHANNEL_DIAGNOSTIC_REGISTER_OPEN_HI = 4;
    localparam int CHANNEL_DIAGNOSTIC_REGISTER_OC_LO = 3;
    localparam int CHANNEL_DIAGNOSTIC_REGISTER_OT_LO = 1;
    localparam int CHANNEL_DIAGNOSTIC_REGISTER_OPEN_LO = 0;
    // fault map / interrupt layout: bit0 oc, bit1 open, bit2 link, bit3 overtemp
    localparam int EV_OC = 0;
    localparam int EV_OPEN = 1;
    localparam int EV_LINK = 2;
    localparam int EV_OT = 3;
    localparam logic [3:0] FAULT_MAP_RST = 4'hD;
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [N_CH-1:0] oc;
        logic [N_CH-1:0] open;
        logic [N_CH-1:0] ot;
    } ch_flags_t;

    typedef struct packed {
        logic [3:0] all_overtemp;
        logic supply_os;
        logic supply_low;
    } supply_t;
endpackage

// *** rtl/switch_channel_diagnostics.sv ***
// switch_channel_diagnostics: per-channel fault flags, link error shutdown, indicators, apb
//
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/1ps
// How it works
// - over-current flag only on enabled channel
// - over-current turns channel off, sets flag
// - fault pin active-low open-drain, mappable
// - open-load warning only on disabled channel
// - open load sets flag, asserts open pin
// - enable bit 0 drives channel one
// - link watched; error sets flag, shuts down
// - outputs off until error gone and cleared
// - dead switch side gives link error
// - dead logic side forces outputs off
// - channel inputs on own one-way path
// - state pins mirror actual state bits
// - over-current clears state bit and pin
// - one device on the apb bus, no daisy chain
// - host reads status, clears, configures
// - summary register layout, read-only, zero reset except supply bits 5:4, which follow the supply inputs
// - pair register flag bit positions
module switch_channel_diagnostics
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // apb slave
    input wire swdiag_pkg::apb_req_t apb_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // host parallel channel inputs
    input wire logic [3:0] channel_parallel_input_in,
    // switch side analogue comparators
    input wire logic [3:0] over_current_in,
    input wire logic [3:0] open_load_in,
    input wire logic [3:0] channel_overtemp_in,
    input wire swdiag_pkg::supply_t supply_in,
    // barrier link health
    input wire logic link_ok_in,
    input wire logic switch_side_alive_in,
    input wire logic logic_side_alive_in,
    // switch drive across the one-way paths
    output logic [3:0] switch_drive_out,
    // open-drain indicator pins, enable high means pulling low
    output logic fault_indicator_n_out,
    output logic fault_indicator_oe_out,
    output logic open_channel_indicator_n_out,
    output logic open_channel_indicator_oe_out,
    output logic [3:0] channel_state_indicator_n_out,
    output logic [3:0] channel_state_indicator_oe_out,
    // interrupt
    output logic irq_out
);
    import swdiag_pkg::*;

    typedef struct packed {
        ch_flags_t flags;
        logic link_err;
        logic overtemp;
        logic [3:0] enable;
        logic [3:0] drive;
        logic [3:0] fault_map;
        logic [3:0] irq_stat;
        logic [3:0] irq_mask;
        logic [31:0] rdata;
        logic ready;
        logic slverr;
        logic fault_pin;
        logic open_pin;
        logic [3:0] state_pin;
        logic irq;
    } state_t;

    state_t st_ff;
    state_t nxt_st;

    function automatic logic [7:0] pair_reg(input ch_flags_t f, input int lo);
        logic [7:0] r;
        r = REG_RST;
        r[CHANNEL_DIAGNOSTIC_REGISTER_OC_HI] = f.oc[lo+1];
        r[CHANNEL_DIAGNOSTIC_REGISTER_OT_HI] = f.ot[lo+1];
        r[CHANNEL_DIAGNOSTIC_REGISTER_OPEN_HI] = f.open[lo+1];
        r[CHANNEL_DIAGNOSTIC_REGISTER_OC_LO] = f.oc[lo];
        r[CHANNEL_DIAGNOSTIC_REGISTER_OT_LO] = f.ot[lo];
        r[CHANNEL_DIAGNOSTIC_REGISTER_OPEN_LO] = f.open[lo];
        return r;
    endfunction

    logic [3:0] cmd;
    logic link_bad;
    logic access;
    logic wr;
    logic [7:0] summary;
    logic [3:0] events;
    logic clr_hit;

    always_comb
    begin
        nxt_st = st_ff;
        // enable bit 0 and parallel input 0 both steer channel one
        cmd = channel_parallel_input_in | st_ff.enable;
        link_bad = !link_ok_in || !switch_side_alive_in;
        // psel with penable marks the access phase; this block is the only device on the bus
        access = apb_in.psel && apb_in.penable;
        wr = access && apb_in.pwrite;
        // clear only at the taking edge, so the ready cycle cannot wipe a fresh event
        clr_hit = wr && !st_ff.ready && (apb_in.paddr == ADDR_CLEAR);
        events = REG_RST[3:0];

        // sticky flags; a new event in the clear cycle wins
        if (clr_hit)
        begin
            nxt_st.flags.oc = st_ff.flags.oc & ~apb_in.pwdata[3:0];
            nxt_st.flags.open = st_ff.flags.open & ~apb_in.pwdata[7:4];
            nxt_st.flags.ot = st_ff.flags.ot & ~apb_in.pwdata[11:8];
            if (apb_in.pwdata[12])
                nxt_st.link_err = 1'b0;
        end
        nxt_st.flags.oc = nxt_st.flags.oc | (cmd & over_current_in);
        nxt_st.flags.open = nxt_st.flags.open | (~cmd & open_load_in);
        nxt_st.flags.ot = nxt_st.flags.ot | (cmd & channel_overtemp_in);
        nxt_st.overtemp = &supply_in.all_overtemp;
        if (link_bad)
            nxt_st.link_err = 1'b1;
        events[EV_OC] = |(cmd & over_current_in);
        events[EV_OPEN] = |(~cmd & open_load_in);
        events[EV_LINK] = link_bad;
        events[EV_OT] = nxt_st.overtemp;

        // drive: off on over-current, all off while link error latched or far side dead
        nxt_st.drive = cmd & ~over_current_in & ~channel_overtemp_in;
        if (nxt_st.link_err || !logic_side_alive_in || nxt_st.overtemp
            || supply_in.supply_os)
            nxt_st.drive = REG_RST[3:0];

        // indicators follow actual state, not the command
        nxt_st.state_pin = nxt_st.drive;
        nxt_st.open_pin = |nxt_st.flags.open;
        nxt_st.fault_pin = (st_ff.fault_map[EV_OC] && |nxt_st.flags.oc)
            || (st_ff.fault_map[EV_OPEN] && |nxt_st.flags.open)
            || (st_ff.fault_map[EV_LINK] && nxt_st.link_err)
            || (st_ff.fault_map[EV_OT] && nxt_st.overtemp);

        summary = REG_RST;
        summary[SUM_LINK_ERR] = st_ff.link_err;
        summary[SUM_OVERTEMP] = st_ff.overtemp;
        summary[SUM_SUPPLY_OS] = supply_in.supply_os;
        summary[SUM_SUPPLY_LOW] = supply_in.supply_low;
        summary[3:0] = st_ff.flags.oc | st_ff.flags.open | st_ff.flags.ot;

        // apb: one wait state, one-cycle ready in access phase
        nxt_st.ready = access && !st_ff.ready;
        nxt_st.slverr = 1'b0;
        nxt_st.rdata = RD_ZERO;
        if (access && !st_ff.ready)
        begin
            case (apb_in.paddr)
                ADDR_SUMMARY: nxt_st.rdata = {24'h000000, summary};
                ADDR_DIAG21: nxt_st.rdata = {24'h000000, pair_reg(st_ff.flags, 0)};
                ADDR_DIAG43: nxt_st.rdata = {24'h000000, pair_reg(st_ff.flags, 2)};
                ADDR_ENABLE:
                begin
                    nxt_st.rdata = {28'h0000000, st_ff.enable};
                    if (apb_in.pwrite)
                        nxt_st.enable = apb_in.pwdata[3:0];
                end
                ADDR_STATE: nxt_st.rdata = {28'h0000000, st_ff.drive};
                ADDR_FAULT_MAP:
                begin
                    nxt_st.rdata = {28'h0000000, st_ff.fault_map};
                    if (apb_in.pwrite)
                        nxt_st.fault_map = apb_in.pwdata[3:0];
                end
                ADDR_IRQ_STAT: nxt_st.rdata = {28'h0000000, st_ff.irq_stat};
                ADDR_IRQ_MASK:
                begin
                    nxt_st.rdata = {28'h0000000, st_ff.irq_mask};
                    if (apb_in.pwrite)
                        nxt_st.irq_mask = apb_in.pwdata[3:0];
                end
                ADDR_CLEAR: nxt_st.rdata = RD_ZERO;
                default: nxt_st.slverr = 1'b1;
            endcase
        end
        if (wr && !st_ff.ready && apb_in.paddr == ADDR_IRQ_STAT)
            nxt_st.irq_stat = st_ff.irq_stat & ~apb_in.pwdata[3:0];
        nxt_st.irq_stat = nxt_st.irq_stat | events;
        nxt_st.irq = |(nxt_st.irq_stat & nxt_st.irq_mask);
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            st_ff <= '0;
            st_ff.fault_map <= FAULT_MAP_RST;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign prdata_out = st_ff.rdata;
    assign pready_out = st_ff.ready;
    assign pslverr_out = st_ff.slverr;
    assign switch_drive_out = st_ff.drive;
    assign fault_indicator_n_out = 1'b0;
    assign fault_indicator_oe_out = st_ff.fault_pin;
    assign open_channel_indicator_n_out = 1'b0;
    assign open_channel_indicator_oe_out = st_ff.open_pin;
    assign channel_state_indicator_n_out = 4'h0;
    assign channel_state_indicator_oe_out = st_ff.state_pin;
    assign irq_out = st_ff.irq;
endmodule // switch_channel_diagnostics

// *** testbench/load_model.sv ***
// load model: switch-side comparator outputs driven by bench fault commands
`timescale 1ns/1ps
module load_model
(
    // fault commands, bit0 is channel one
    input wire logic [3:0] short_in,
    input wire logic [3:0] open_in,
    // comparator outputs
    output logic [3:0] over_current_out,
    output logic [3:0] open_load_out
);
    // raw comparators also chatter on off channels; the block must qualify them
    assign over_current_out = short_in;
    assign open_load_out = open_in;
endmodule // load_model

// *** testbench/swdiag_assertions.sv ***
// checker: port-level properties of the diagnostics block
`timescale 1ns/1ps
module swdiag_check
(
    // observed ports
    input wire logic clk_in,
    input wire logic rst_in,
    input wire swdiag_pkg::apb_req_t apb_in,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic [3:0] over_current_in,
    input wire logic link_ok_in,
    input wire logic switch_side_alive_in,
    input wire logic logic_side_alive_in,
    input wire logic [3:0] switch_drive_out,
    input wire logic fault_indicator_n_out,
    input wire logic [3:0] channel_state_indicator_oe_out
);
    import swdiag_pkg::*;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);
    sequence take_s;
        apb_in.psel && apb_in.penable && !pready_out;
    endsequence
    sequence off_s;
        ##[1:3] (switch_drive_out == 4'h0);
    endsequence
    answer_one_wait_a: assert property (take_s |=> pready_out)
        else $error("no answer after one wait");
    ready_one_cycle_a: assert property (pready_out |=> !pready_out)
        else $error("ready held too long");
    err_with_ready_a: assert property (pslverr_out |-> pready_out)
        else $error("error without ready");
    fault_pin_low_a: assert property (fault_indicator_n_out == 1'b0)
        else $error("fault pin data not low");
    led_mirror_a: assert property (channel_state_indicator_oe_out == switch_drive_out)
        else $error("state pin differs from drive");
    link_err_off_a: assert property (!link_ok_in |-> off_s)
        else $error("drive on during link error");
    switch_dead_off_a: assert property (!switch_side_alive_in |-> off_s)
        else $error("drive on with switch side dead");
    logic_dead_off_a: assert property (!logic_side_alive_in |-> off_s)
        else $error("drive on with logic side dead");
    oc_turns_off_a: assert property (over_current_in != 4'h0 |=>
        ((switch_drive_out & $past(over_current_in)) == 4'h0))
        else $error("overloaded channel still on");
endmodule // swdiag_check
bind switch_channel_diagnostics swdiag_check u_chk (.clk_in(clk_in), .rst_in(rst_in),
    .apb_in(apb_in), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .over_current_in(over_current_in), .link_ok_in(link_ok_in),
    .switch_side_alive_in(switch_side_alive_in), .logic_side_alive_in(logic_side_alive_in),
    .switch_drive_out(switch_drive_out), .fault_indicator_n_out(fault_indicator_n_out),
    .channel_state_indicator_oe_out(channel_state_indicator_oe_out));

// *** testbench/test_switch_channel_diagnostics.sv ***
// testbench: apb host sequences against the diagnostics block
`timescale 1ns/1ps
module test_switch_channel_diagnostics;
    import swdiag_pkg::*;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic lok = 1'b1, ssa = 1'b1, lsa = 1'b1, rdy, er, se, irq, fo, oo, a;
    logic [3:0] cpi = 4'h0, shrt = 4'h0, opn = 4'h0, oc, ol, drv, soe;
    logic [31:0] prd, rd;
    apb_req_t apb = '0;
    int err_total = 0;
    int total_checks = 0;
    always #50 clk_in = ~clk_in;
    load_model lm (.short_in(shrt), .open_in(opn), .over_current_out(oc), .open_load_out(ol));
    switch_channel_diagnostics DUT (.clk_in(clk_in), .rst_in(rst_in), .apb_in(apb),
        .prdata_out(prd), .pready_out(rdy), .pslverr_out(er), .channel_parallel_input_in(cpi),
        .over_current_in(oc), .open_load_in(ol), .channel_overtemp_in(4'h0), .supply_in('0),
        .link_ok_in(lok), .switch_side_alive_in(ssa), .logic_side_alive_in(lsa),
        .switch_drive_out(drv), .fault_indicator_n_out(), .fault_indicator_oe_out(fo),
        .open_channel_indicator_n_out(), .open_channel_indicator_oe_out(oo),
        .channel_state_indicator_n_out(), .channel_state_indicator_oe_out(soe), .irq_out(irq));
    task automatic complete_run(input int extra);
        err_total += extra;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("mismatch %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    task automatic xfer(input logic w, input logic [7:0] ad, input logic [31:0] d);
        int n;
        @(posedge clk_in);
        apb <= '{1'b1, 1'b0, w, ad, d};
        @(posedge clk_in);
        apb.penable <= 1'b1;
        for (n = 0; n < 20 && rdy !== 1'b1; n++)
            @(posedge clk_in);
        if (n == 20)
            complete_run(1);
        rd = prd;
        se = er;
        apb <= '0;
    endtask
    task automatic rdchk(input logic [7:0] ad, input logic [31:0] e);
        xfer(1'b0, ad, 32'h0);
        chk($sformatf("reg %0h", ad), e, rd);
    endtask
    initial
    begin
        step(4);
        rst_in <= 1'b0;
        rdchk(ADDR_SUMMARY, 32'h0);
        rdchk(ADDR_DIAG43, 32'h0);
        xfer(1'b0, 8'hFC, 32'h0);
        chk("slverr", 32'h1, se);
        xfer(1'b1, ADDR_ENABLE, 32'h1);
        cpi <= 4'h2;
        step(3);
        chk("drive", 32'h3, drv);
        chk("state pins", 32'h3, soe);
        shrt <= 4'hA;
        step(4);
        chk("drive", 32'h1, drv);
        chk("state pins", 32'h1, soe);
        chk("fault pin", 32'h1, fo);
        shrt <= 4'h0;
        rdchk(ADDR_DIAG21, 32'h80);
        rdchk(ADDR_DIAG43, 32'h0);
        rdchk(ADDR_SUMMARY, 32'h2);
        rdchk(ADDR_IRQ_STAT, 32'h1 << EV_OC);
        xfer(1'b1, ADDR_FAULT_MAP, 32'h0);
        step(2);
        chk("fault pin", 32'h0, fo);
        xfer(1'b1, ADDR_IRQ_MASK, 32'hF);
        step(2);
        a = irq;
        xfer(1'b1, ADDR_IRQ_MASK, 32'h0);
        step(2);
        chk("irq mask", 32'h1, a ^ irq);
        xfer(1'b1, ADDR_CLEAR, 32'h2);
        xfer(1'b1, ADDR_IRQ_STAT, 32'hF);
        xfer(1'b1, ADDR_IRQ_MASK, 32'hF);
        step(2);
        chk("irq", 32'h0, irq);
        chk("drive", 32'h3, drv);
        opn <= 4'h5;
        step(3);
        rdchk(ADDR_DIAG43, 32'h1);
        rdchk(ADDR_DIAG21, 32'h0);
        chk("open pin", 32'h1, oo);
        chk("drive", 32'h3, drv);
        opn <= 4'h0;
        xfer(1'b1, ADDR_CLEAR, 32'hF0);
        lok <= 1'b0;
        step(3);
        chk("drive", 32'h0, drv);
        lok <= 1'b1;
        step(3);
        chk("drive", 32'h0, drv);
        rdchk(ADDR_SUMMARY, 32'h80);
        xfer(1'b1, ADDR_CLEAR, 32'h1000);
        step(3);
        chk("drive", 32'h3, drv);
        ssa <= 1'b0;
        step(3);
        rdchk(ADDR_SUMMARY, 32'h80);
        ssa <= 1'b1;
        xfer(1'b1, ADDR_CLEAR, 32'h1000);
        lsa <= 1'b0;
        step(3);
        chk("drive", 32'h0, drv);
        complete_run(0);
    end
endmodule // test_switch_channel_diagnostics
